// >>> logic/rate_trim.sv
// Oscillation rate trim: corrected one-second count and 1 Hz pulse output
`timescale 1ns/1ps

// Contract
// - Seven-bit trim code is a two's-complement signed value.
// - Codes 0, +1, -64 and -63 apply no correction.
// - Fast clock: correction is the code's distance above 01h.
// - Slow clock: correction is the code's distance below 80h.
// - Step select 0 gives about 1.5 ppm steps, 1 gives about 0.5 ppm.
// - Register holds step select in bit 7, trim code in bits 6..0.
// - One second per 20 or 60 second interval is altered.
// - Raw oscillator output is never touched by trimming.
// - Control pattern 0,0,x,x,0,0,1,1 gives 1 Hz pulse on interrupt pin.
// - Exactly one 1 Hz period per interval changes; others nominal.
// - Power-up flag clears step select and all trim bits.
module rate_trim
  import rate_trim_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Oscillator tick enable and raw oscillator level
  input wire logic OSC_TICK_IN,
  input wire logic OSC_LEVEL_IN,
  // Power-up flag
  input wire logic POWER_UP_FLAG_IN,
  // Rate trim register access
  input wire logic TRIM_WR_IN,
  input wire logic [7:0] TRIM_WDATA_IN,
  output logic [7:0] TRIM_RDATA_OUT,
  // First control register access
  input wire logic CTRL1_WR_IN,
  input wire logic [7:0] CTRL1_WDATA_IN,
  output logic [7:0] CTRL1_RDATA_OUT,
  // Time count and observation outputs
  output logic SEC_PULSE_OUT,
  output logic INT_N_OUT,
  output logic RAW_OSC_OUTPUT_OUT
);

  trim_reg_type rate_trim_control;
  logic [7:0] ctrl1;
  logic [15:0] tick_count;
  logic [5:0] sec_count;
  logic sec_pulse;
  logic int_n;
  logic raw_osc;

  // Register write, cleared by the power-up flag
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || POWER_UP_FLAG_IN) begin
      rate_trim_control <= TRIM_RESET;
      ctrl1 <= CTRL1_RESET;
    end else begin
      if (TRIM_WR_IN) begin
        rate_trim_control <= TRIM_WDATA_IN;
      end
      if (CTRL1_WR_IN) begin
        ctrl1 <= CTRL1_WDATA_IN;
      end
    end
  end

  // Code decode: sign bit picks fast or slow correction
  wire logic [6:0] code = rate_trim_control.trim_code;
  wire logic step_sel = rate_trim_control.trim_step_select;
  wire logic is_slow = code[TRIM_MSB];
  wire logic is_neutral = (code == CODE_ZERO) || (code == CODE_PLUS1) ||
    (code == CODE_M64) || (code == CODE_M63);
  wire logic [7:0] fast_dist = {1'b0, code} - FAST_BASE;
  wire logic [7:0] slow_dist = SLOW_BASE - {1'b0, code};

  // Interval length follows the step select
  wire logic [5:0] last_sec = step_sel ? LAST_SEC_STEP1 :
    LAST_SEC_STEP0;
  wire logic at_last_sec = (sec_count >= last_sec);

  // Length of the current second, one tick per trim step
  wire logic [15:0] corr_len = is_slow ?
    NOMINAL_TICKS + {8'h00, slow_dist} :
    NOMINAL_TICKS - {8'h00, fast_dist};
  wire logic [15:0] sec_len = (at_last_sec && !is_neutral) ? corr_len :
    NOMINAL_TICKS;
  wire logic sec_end = OSC_TICK_IN && (tick_count >= sec_len - 16'h0001);

  // Pulse-mode 1 Hz output select
  wire logic pulse_en = ((ctrl1 & CTRL1_MASK) == CTRL1_PULSE_1HZ);
  wire logic next_int_n = !(pulse_en && (tick_count < HALF_TICKS));

  // Second prescaler and interval second counter
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      tick_count <= 16'h0000;
      sec_count <= 6'h00;
      sec_pulse <= 1'b0;
    end else begin
      sec_pulse <= sec_end;
      if (sec_end) begin
        tick_count <= 16'h0000;
        sec_count <= at_last_sec ? 6'h00 : sec_count + 6'h01;
      end else if (OSC_TICK_IN) begin
        tick_count <= tick_count + 16'h0001;
      end
    end
  end

  // Observation outputs; raw oscillator is only retimed
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      int_n <= 1'b1;
      raw_osc <= 1'b0;
    end else begin
      int_n <= next_int_n;
      raw_osc <= OSC_LEVEL_IN;
    end
  end

  // Output drive
  assign TRIM_RDATA_OUT = rate_trim_control;
  assign CTRL1_RDATA_OUT = ctrl1;
  assign SEC_PULSE_OUT = sec_pulse;
  assign INT_N_OUT = int_n;
  assign RAW_OSC_OUTPUT_OUT = raw_osc;

  // Checks on the trim behaviour
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  power_clear_a: assert property (
    POWER_UP_FLAG_IN |=> (TRIM_RDATA_OUT == TRIM_RESET))
    else $error("trim not cleared by power-up flag");

  trim_write_a: assert property (
    (TRIM_WR_IN && !POWER_UP_FLAG_IN) |=>
    (TRIM_RDATA_OUT == $past(TRIM_WDATA_IN)))
    else $error("trim register write lost");

  neutral_len_a: assert property (
    (TRIM_RDATA_OUT[6:0] == 7'h00 || TRIM_RDATA_OUT[6:0] == 7'h01 ||
    TRIM_RDATA_OUT[6:0] == 7'h40 || TRIM_RDATA_OUT[6:0] == 7'h41) |->
    (sec_len == NOMINAL_TICKS))
    else $error("neutral code altered second length");

  fast_len_a: assert property (
    (at_last_sec && !code[6] && code > 7'h01) |->
    (sec_len == 16'h8001 - {9'h000, code}))
    else $error("fast correction length wrong");

  slow_len_a: assert property (
    (at_last_sec && code >= 7'h42) |->
    (sec_len == 16'h8080 - {9'h000, code}))
    else $error("slow correction length wrong");

  nominal_sec_a: assert property (
    !at_last_sec |-> (sec_len == NOMINAL_TICKS))
    else $error("uncorrected second not nominal");

  interval_wrap_a: assert property (
    (sec_end && sec_count == (step_sel ? 6'h3B : 6'h13)) |=>
    (sec_count == 6'h00))
    else $error("correction interval length wrong");

  sec_pulse_a: assert property (
    (OSC_TICK_IN && tick_count == sec_len - 16'h0001) |=>
    (SEC_PULSE_OUT && tick_count == 16'h0000) ##1 !SEC_PULSE_OUT)
    else $error("second pulse not at end of count");

  raw_osc_a: assert property (
    ##1 (RAW_OSC_OUTPUT_OUT == $past(OSC_LEVEL_IN)))
    else $error("raw oscillator output disturbed");

  pulse_off_a: assert property (
    !pulse_en |=> INT_N_OUT)
    else $error("interrupt pin driven without pulse mode");

  power_ctrl_a: assert property (
    POWER_UP_FLAG_IN |=> (CTRL1_RDATA_OUT == CTRL1_RESET))
    else $error("control register not cleared by power-up flag");

  ctrl1_write_a: assert property (
    (CTRL1_WR_IN && !POWER_UP_FLAG_IN) |=>
    (CTRL1_RDATA_OUT == $past(CTRL1_WDATA_IN)))
    else $error("control register write lost");

  slow_dir_a: assert property (
    (at_last_sec && TRIM_RDATA_OUT[6:0] >= 7'h42) |->
    (sec_len > NOMINAL_TICKS))
    else $error("negative code did not lengthen the second");

  fast_dir_a: assert property (
    (at_last_sec && TRIM_RDATA_OUT[6:0] >= 7'h02 &&
    TRIM_RDATA_OUT[6:0] <= 7'h3F) |-> (sec_len < NOMINAL_TICKS))
    else $error("positive code did not shorten the second");

  step_range_a: assert property (
    (sec_len >= 16'h7FC2) && (sec_len <= 16'h803E))
    else $error("second length beyond trim range");

  sec_step_a: assert property (
    (sec_end && !at_last_sec) |=>
    (sec_count == $past(sec_count) + 6'h01))
    else $error("interval second count skipped");

  count_hold_a: assert property (
    !OSC_TICK_IN |=> $stable(tick_count))
    else $error("second count moved without a tick");

  pulse_once_a: assert property (
    SEC_PULSE_OUT |=> !SEC_PULSE_OUT)
    else $error("second pulse longer than one cycle");

  interval_max_a: assert property (
    sec_count <= LAST_SEC_STEP1)
    else $error("interval second count out of range");

  pulse_low_a: assert property (
    (pulse_en && tick_count < HALF_TICKS) |=> !INT_N_OUT)
    else $error("interrupt pin not low in first half second");

  pulse_high_a: assert property (
    (tick_count >= HALF_TICKS) |=> INT_N_OUT)
    else $error("interrupt pin low in second half second");

endmodule

// >>> logic/rate_trim_pkg.sv
// Constants and types for the oscillation rate trim block
package rate_trim_pkg;

  // Rate trim control register layout
  typedef struct packed {
    logic trim_step_select;
    logic [6:0] trim_code;
  } trim_reg_type;

  localparam int TRIM_STEP_BIT = 7;
  localparam int TRIM_MSB = 6;
  localparam int TRIM_LSB = 0;
  localparam logic [7:0] TRIM_RESET = 8'h00;

  // Trim codes that apply no correction
  localparam logic [6:0] CODE_ZERO = 7'h00;
  localparam logic [6:0] CODE_PLUS1 = 7'h01;
  localparam logic [6:0] CODE_M64 = 7'h40;
  localparam logic [6:0] CODE_M63 = 7'h41;
  // Fast clock distance base, slow clock distance base
  localparam logic [7:0] FAST_BASE = 8'h01;
  localparam logic [7:0] SLOW_BASE = 8'h80;

  // Oscillator ticks per nominal second and per pulse-mode low half
  localparam logic [15:0] NOMINAL_TICKS = 16'h8000;
  localparam logic [15:0] HALF_TICKS = 16'h4000;

  // Correction interval lengths, in seconds, minus one
  localparam logic [5:0] LAST_SEC_STEP0 = 6'h13;
  localparam logic [5:0] LAST_SEC_STEP1 = 6'h3B;

  // First control register: pulse-mode 1 Hz pattern (0,0,x,x,0,0,1,1)
  localparam logic [7:0] CTRL1_MASK = 8'hCF;
  localparam logic [7:0] CTRL1_PULSE_1HZ = 8'h03;
  localparam logic [7:0] CTRL1_RESET = 8'h00;

endpackage

// >>> dv/host_model.sv
// Host model: register writes as one-cycle strobes
`timescale 1ns/1ps
module host_model
  import rate_trim_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Write strobes and shared write data
  output logic trim_wr_out,
  output logic ctrl1_wr_out,
  output trim_reg_type wdata_out
);
  // Idle at time zero
  initial begin
    trim_wr_out = 1'b0;
    ctrl1_wr_out = 1'b0;
    wdata_out = 8'h00;
  end

  // One strobe per call, calls spaced two cycles
  task automatic wr(input logic to_ctrl, input logic [7:0] d);
    @(posedge clk_in);
    trim_wr_out <= !to_ctrl;
    ctrl1_wr_out <= to_ctrl;
    wdata_out <= d;
    @(posedge clk_in);
    trim_wr_out <= 1'b0;
    ctrl1_wr_out <= 1'b0;
  endtask

  // Trim word with value -62..+63, two's complement
  function automatic logic [7:0] legal_trim();
    logic [6:0] code;
    code = 7'($urandom % 126) - 7'h3E;
    return {1'($urandom), code};
  endfunction
endmodule

// >>> dv/testbench.sv
// Testbench: registers, power-up clear, raw clock, 1 Hz pulse
`timescale 1ns/1ps
module testbench
  import rate_trim_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, tick = 1'b1, lvl = 1'b0, puf = 1'b0;
  logic trim_wr, ctrl1_wr, sec, int_n, raw;
  logic timed_out = 1'b0;
  logic [7:0] trim_rd, ctrl1_rd;
  trim_reg_type wdata;
  int fail_count = 0;
  int n_compared = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  rate_trim dut (.CLK_IN(clk), .RST_IN(rst), .OSC_TICK_IN(tick),
    .OSC_LEVEL_IN(lvl), .POWER_UP_FLAG_IN(puf), .TRIM_WR_IN(trim_wr),
    .TRIM_WDATA_IN(wdata), .TRIM_RDATA_OUT(trim_rd),
    .CTRL1_WR_IN(ctrl1_wr), .CTRL1_WDATA_IN(wdata),
    .CTRL1_RDATA_OUT(ctrl1_rd), .SEC_PULSE_OUT(sec), .INT_N_OUT(int_n),
    .RAW_OSC_OUTPUT_OUT(raw));
  host_model host (.clk_in(clk), .trim_wr_out(trim_wr),
    .ctrl1_wr_out(ctrl1_wr), .wdata_out(wdata));

  // Compare and count
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Counts, verdict and end of run
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Control word one mask bit away from the pulse-mode pattern
  function automatic logic [7:0] near_miss(input int unsigned r);
    logic [7:0] m;
    m = 8'h01 << (r % 8);
    if ((m & CTRL1_MASK) == 8'h00) m = 8'h80;
    return CTRL1_PULSE_1HZ ^ m;
  endfunction

  // Ticks to the next second pulse, low cycles of the pin, and the
  // cycle whose tick ends the low half; ticks come at pct percent
  task automatic second(input int pct, output int len, output int low,
      output int half_at);
    int cyc;
    len = 0;
    low = 0;
    half_at = 0;
    cyc = 0;
    do begin
      @(posedge clk);
      cyc++;
      if (tick === 1'b1) len++;
      if (tick === 1'b1 && len == int'(HALF_TICKS)) half_at = cyc;
      tick <= (($urandom % 100) < pct);
      #1;
      if (int_n === 1'b0) low++;
      if (cyc > 40000) timed_out = 1'b1;
    end while (sec !== 1'b1 && timed_out === 1'b0);
    if (timed_out === 1'b1) fail_count++;
  endtask

  // Main sequence
  initial begin
    int len, low, half_at;
    logic [7:0] d;
    d = 8'($urandom(73));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    cmp(16'(trim_rd), 16'(TRIM_RESET));
    cmp(16'(ctrl1_rd), 16'(CTRL1_RESET));
    cmp(16'(int_n), 16'h0001);
    cmp(16'(sec), 16'h0000);
    cmp(16'(raw), 16'h0000);
    // Random legal words, then both range ends, read back whole
    for (int i = 0; i < 10; i++) begin
      d = (i == 8) ? 8'h3F : (i == 9) ? 8'hC2 : host.legal_trim();
      host.wr(1'b0, d);
      #1;
      cmp(16'(trim_rd), 16'(d));
    end
    // Raw level one clock late, trim nonzero
    repeat (16) begin
      @(posedge clk);
      d = 8'($urandom);
      lvl <= d[0];
      @(posedge clk);
      #1;
      cmp(16'(raw), 16'(d[0]));
    end
    // Power-up flag clears both and beats writes to both
    host.wr(1'b0, 8'hA5);
    host.wr(1'b1, 8'h30);
    puf <= 1'b1;
    host.wr(1'b1, 8'hFF);
    host.wr(1'b0, 8'h85);
    puf <= 1'b0;
    #1;
    cmp(16'(trim_rd), 16'h0000);
    cmp(16'(ctrl1_rd), 16'h0000);
    // Pin stays high for a control word just off the pulse pattern
    host.wr(1'b1, near_miss($urandom));
    low = 0;
    repeat (1000) begin
      @(posedge clk);
      #1;
      if (int_n !== 1'b1) low++;
    end
    cmp(16'(low), 16'h0000);
    // Pulse mode with random don't-care bits, random legal trim
    host.wr(1'b1, 8'h03 | (8'($urandom) & 8'h30));
    host.wr(1'b0, host.legal_trim());
    second(100, len, low, half_at);
    // Full second with gaps between oscillator ticks
    second(94, len, low, half_at);
    cmp(16'(len), NOMINAL_TICKS);
    cmp(16'(low), 16'(half_at));
    print_verdict();
  end
endmodule
